// File: dplw_checker.sv
// Port-level assertions for the pointer list walker
`timescale 1ns/1ps
module dplw_checker (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Command and completion
	input wire logic CMD_VALID,
	input wire logic CMD_READY,
	input wire logic [31:0] CMD_LEN,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic ERR,
	input wire logic [2:0] ERR_CODE,
	// Memory reads
	input wire logic MEM_REQ_VALID,
	input wire logic MEM_REQ_READY,
	input wire logic [63:0] MEM_REQ_ADDR,
	input wire logic MEM_RSP_VALID,
	// Transfer stream
	input wire logic XFER_VALID,
	input wire logic XFER_READY,
	input wire logic [63:0] XFER_ADDR,
	input wire logic [31:0] XFER_LEN
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic out_q;
	// Read in flight; a second request would break sequential fetch
	always_ff @(posedge CLK) begin
		if (RST) begin
			out_q <= 1'b0;
		end else if (MEM_RSP_VALID) begin
			out_q <= 1'b0;
		end else if (MEM_REQ_VALID && MEM_REQ_READY) begin
			out_q <= 1'b1;
		end
	end
	property p_one_read;
		out_q |-> !MEM_REQ_VALID;
	endproperty
	a_one_read: assert property (p_one_read) else $error("read overlap");
	property p_req_hold;
		MEM_REQ_VALID && !MEM_REQ_READY |=>
			MEM_REQ_VALID && $stable(MEM_REQ_ADDR);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("req dropped");
	property p_req_qword;
		MEM_REQ_VALID |-> MEM_REQ_ADDR[2:0] == 3'h0;
	endproperty
	a_req_qword: assert property (p_req_qword) else $error("req unaligned");
	property p_xfer_hold;
		XFER_VALID && !XFER_READY |=>
			XFER_VALID && $stable(XFER_ADDR) && $stable(XFER_LEN);
	endproperty
	a_xfer_hold: assert property (p_xfer_hold) else $error("xfer moved");
	property p_no_null;
		XFER_VALID |-> XFER_LEN != 32'h0;
	endproperty
	a_no_null: assert property (p_no_null) else $error("null xfer");
	property p_zero_cmd;
		CMD_VALID && CMD_READY && CMD_LEN == 32'h0 |-> ##2 DONE;
	endproperty
	a_zero_cmd: assert property (p_zero_cmd) else $error("zero len");
	property p_err_code;
		ERR |-> ERR_CODE != 3'h0 && !DONE;
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad code");
	property p_done_clean;
		DONE |-> ERR_CODE == 3'h0 && CMD_READY && !BUSY;
	endproperty
	a_done_clean: assert property (p_done_clean) else $error("bad done");
	// Main scenarios reached
	c_err: cover property (ERR);
	c_stall: cover property (XFER_VALID && !XFER_READY);
	c_done: cover property (DONE);
endmodule

bind dplw_walker dplw_checker u_chk (.CLK(CLK), .RST(RST),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_LEN(CMD_LEN),
	.BUSY(BUSY), .DONE(DONE), .ERR(ERR), .ERR_CODE(ERR_CODE),
	.MEM_REQ_VALID(MEM_REQ_VALID), .MEM_REQ_READY(MEM_REQ_READY),
	.MEM_REQ_ADDR(MEM_REQ_ADDR), .MEM_RSP_VALID(MEM_RSP_VALID),
	.XFER_VALID(XFER_VALID), .XFER_READY(XFER_READY),
	.XFER_ADDR(XFER_ADDR), .XFER_LEN(XFER_LEN));

// File: dplw_defs.svh
// Constants for the data pointer list walker: field positions and sizes
`ifndef DPLW_DEFS_SVH
`define DPLW_DEFS_SVH

// ************************************************************
// Page pointer entry layout
// ************************************************************
`define DPLW_ENTRY_BYTES 64'h0000000000000008
`define DPLW_ENTRY_RSVD_MASK 64'h0000000000000003
`define DPLW_LIST_ALIGN_MASK 64'h0000000000000007
`define DPLW_PAGE_SHIFT_BASE 6'h0c
`define DPLW_MPS_MAX 4'hf

// ************************************************************
// Scatter-gather descriptor layout
// ************************************************************
`define DPLW_DESC_BYTES 64'h0000000000000010
`define DPLW_DESC_SHIFT 4
`define DPLW_DESC_ADDR_LSB 0
`define DPLW_DESC_LEN_LSB 64
`define DPLW_DESC_ZERO_LSB 120
`define DPLW_DESC_TYPE_LSB 124

// ************************************************************
// Reset values
// ************************************************************
`define DPLW_RST_ADDR 64'h0000000000000000
`define DPLW_RST_LEN 32'h00000000
`define DPLW_RST_SEGLEFT 28'h0000000

`endif

// File: dplw_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dplw_fifo #(
	parameter int W = 96,
	parameter int D = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	// Depth must be a power of two so the pointers wrap by themselves
	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("dplw_fifo: depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_st_t;

	fifo_st_t q, d;
	logic push, pop;

	// Honest flags: full stops the source, empty stops the sink
	assign in_ready = (q.cnt != (AW+1)'(D));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data;
			d.wr = q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = q.rd + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	// Register; storage needs no reset, only the pointers and the count do
	always_ff @(posedge clk) begin
		if (rst) begin
			q.wr <= '0;
			q.rd <= '0;
			q.cnt <= '0;
			q.mem <= d.mem;
		end else begin
			q <= d;
		end
	end
endmodule

// File: dplw_mem_model.sv
// Host memory model holding pointer lists and descriptor segments
`timescale 1ns/1ps
module dplw_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Requests
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [63:0] req_addr,
	// Replies
	output logic rsp_valid = 1'b0,
	output logic [127:0] rsp_data,
	// Pace
	input wire logic slow
);
	logic [127:0] store [logic [63:0]];
	logic [127:0] last_q = 128'h0;
	logic [63:0] addr_q = 64'h0;
	logic pend_q = 1'b0;
	logic [2:0] wait_q = 3'h0;
	logic [1:0] pace_q = 2'h0;
	// Slow pace accepts one edge in four
	assign req_ready = !pend_q && (!slow || pace_q == 2'h3);
	// Idle reply lines carry the inverse, never a stale match
	assign rsp_data = rsp_valid ? last_q : ~last_q;
	// One reply per request, after a short or long wait
	always @(posedge clk) begin
		pace_q <= pace_q + 2'h1;
		rsp_valid <= 1'b0;
		if (rst) begin
			pend_q <= 1'b0;
		end else if (req_valid && req_ready) begin
			pend_q <= 1'b1;
			addr_q <= req_addr;
			wait_q <= slow ? 3'h4 : 3'h0;
		end else if (pend_q && wait_q != 3'h0) begin
			wait_q <= wait_q - 3'h1;
		end else if (pend_q) begin
			// Sixteen bytes from the address, little endian
			last_q <= store.exists(addr_q) ? store[addr_q] :
				{4{32'h5a5ac3c3}};
			rsp_valid <= 1'b1;
			pend_q <= 1'b0;
		end
	end
endmodule

// File: dplw_pkg.sv
// Types used by the data pointer list walker for its state, descriptors and errors
package dplw_pkg;

	// Walker states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PG_FIRST = 4'h1,
		ST_PG_SECOND = 4'h2,
		ST_PG_FETCH = 4'h3,
		ST_PG_WAIT = 4'h4,
		ST_SG_FETCH = 4'h5,
		ST_SG_WAIT = 4'h6,
		ST_SG_EVAL = 4'h7,
		ST_SG_NEXT = 4'h8,
		ST_EMIT = 4'h9,
		ST_FINISH = 4'ha
	} dplw_state_t;

	// Descriptor type codes
	typedef enum logic [3:0] {
		DT_DATA = 4'h0,
		DT_BITBKT = 4'h1,
		DT_SEG = 4'h2,
		DT_LAST = 4'h3,
		DT_VENDOR = 4'hf
	} dplw_dtype_t;

	// Error causes reported with the error pulse
	typedef enum logic [2:0] {
		ER_NONE = 3'h0,
		ER_CHAIN_POS = 3'h1,
		ER_LAST_CHAIN = 3'h2,
		ER_TYPE = 3'h3,
		ER_WRAP = 3'h4,
		ER_SHORT = 3'h5,
		ER_ZERO = 3'h6
	} dplw_err_t;

	// Whole walker state
	typedef struct packed {
		dplw_state_t st;
		dplw_state_t ret;
		logic scatter_gather_list;
		logic [3:0] mps;
		logic [31:0] rem;
		logic [63:0] ptr1;
		logic [63:0] ptr2;
		logic [63:0] list_addr;
		logic [63:0] em_addr;
		logic [31:0] em_len;
		logic [27:0] seg_left;
		logic in_last;
		logic [127:0] desc;
		logic done;
		logic err;
		dplw_err_t err_code;
	} dplw_walk_t;

endpackage

// File: dplw_tb.sv
// Self-checking testbench for the pointer list walker
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cv = 1'b0, sg = 1'b0, slow = 1'b0, xr = 1'b1;
	logic [63:0] p1 = 64'h0, p2 = 64'h0, mra, xa;
	logic [31:0] ln = 32'h0, xl;
	logic [3:0] mps = 4'h0;
	logic [127:0] msd;
	logic [2:0] ec;
	logic cr, mrv, mrr, msv, xv, busy, done, err;
	logic [63:0] ga[$], ea[$];
	logic [31:0] gl[$], el[$];
	int errors = 0;
	int checked = 0;
	int n;
	dplw_walker #(.FIFO_DEPTH(8)) DUT (.CLK(clk), .RST(rst),
		.CMD_VALID(cv), .CMD_READY(cr), .CMD_SGL(sg), .CMD_PTR1(p1),
		.CMD_PTR2(p2), .CMD_LEN(ln), .MEMORY_PAGE_SIZE_CONFIG(mps),
		.MEM_REQ_VALID(mrv), .MEM_REQ_READY(mrr), .MEM_REQ_ADDR(mra),
		.MEM_RSP_VALID(msv), .MEM_RSP_DATA(msd), .XFER_VALID(xv),
		.XFER_READY(xr), .XFER_ADDR(xa), .XFER_LEN(xl), .BUSY(busy),
		.DONE(done), .ERR(err), .ERR_CODE(ec));
	dplw_mem_model u_mem (.clk(clk), .rst(rst), .req_valid(mrv),
		.req_ready(mrr), .req_addr(mra), .rsp_valid(msv),
		.rsp_data(msd), .slow(slow));
	always #5 clk = ~clk;
	// Record every transfer the data mover takes
	always @(posedge clk) begin
		if (!rst && xv && xr) begin
			ga.push_back(xa);
			gl.push_back(xl);
		end
	end
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic xp(input logic [63:0] a, input logic [31:0] l);
		ea.push_back(a);
		el.push_back(l);
	endtask
	function automatic logic [127:0] dsc(input logic [3:0] t,
		input logic [31:0] l, input logic [63:0] a);
		return {t, 28'h0, l, a};
	endfunction
	// Offer one command and hold it until taken
	task automatic issue(input logic s, input logic [63:0] a,
		input logic [63:0] b, input logic [31:0] l);
		@(negedge clk);
		cv = 1'b1;
		sg = s;
		p1 = a;
		p2 = b;
		ln = l;
		while (!cr) @(negedge clk);
		@(negedge clk);
		cv = 1'b0;
	endtask
	// Wait for completion, drain, compare the transfer list
	task automatic fin(input logic e, input logic [2:0] c);
		n = 0;
		while (!(done || err) && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(done || err, 1'b1);
		chk(err, e);
		chk(ec, c);
		n = 0;
		while (xv && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(xv, 1'b0);
		chk(ga.size(), ea.size());
		foreach (ea[i]) begin
			chk(ga[i], ea[i]);
			chk(gl[i], el[i]);
		end
		ga.delete();
		gl.delete();
		ea.delete();
		el.delete();
	endtask
	task automatic t_page;
		xp(64'h100000010, 32'd100);
		issue(1'b0, 64'h100000013, 64'h0, 32'd100);
		fin(1'b0, 3'h0);
		xp(64'h10000ff0, 32'h10);
		xp(64'h20000000, 32'h10);
		issue(1'b0, 64'h10000ff0, 64'h20000000, 32'h20);
		fin(1'b0, 3'h0);
		issue(1'b0, 64'h1000, 64'h0, 32'h0);
		fin(1'b0, 3'h0);
		mps = 4'h1;
		xp(64'h400000100, 32'h1f00);
		xp(64'h500000000, 32'h2000);
		issue(1'b0, 64'h400000100, 64'h500000000, 32'h3f00);
		fin(1'b0, 3'h0);
		mps = 4'h0;
	endtask
	// List chained from a mid-page pointer, mover stalled, slow memory
	task automatic t_chain;
		slow = 1'b1;
		xr = 1'b0;
		u_mem.store[64'h4ff0] = {64'hffffffffffffffff, 64'h21000};
		u_mem.store[64'h4ff8] = {64'hffffffffffffffff, 64'h5000};
		xp(64'h10000, 32'h1000);
		xp(64'h21000, 32'h1000);
		for (int i = 0; i < 9; i++) begin
			u_mem.store[64'h5000 + 8 * i] = 64'h30000 + 64'h1000 * i;
			xp(64'h30000 + 64'h1000 * i, 32'h1000);
		end
		issue(1'b0, 64'h10000, 64'h4ff0, 32'hb000);
		repeat (300) @(negedge clk);
		chk(busy, 1'b1);
		chk(ga.size(), 0);
		xr = 1'b1;
		fin(1'b0, 3'h0);
		slow = 1'b0;
	endtask
	task automatic t_sgl;
		logic [3:0] ty [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'he, 4'hf};
		logic [2:0] cd [6] = '{3'h3, 3'h1, 3'h1, 3'h3, 3'h3, 3'h3};
		u_mem.store[64'h8000] = dsc(4'h0, 32'd5, 64'h1003);
		u_mem.store[64'h8010] = 128'h0;
		u_mem.store[64'h8020] = dsc(4'h0, 32'd100, 64'h2001);
		xp(64'h1003, 32'd5);
		xp(64'h2001, 32'd100);
		issue(1'b1, 64'h8000, {4'h3, 28'h0, 32'd48}, 32'd105);
		fin(1'b0, 3'h0);
		xp(64'hffffffffffffffe0, 32'h20);
		issue(1'b1, 64'hffffffffffffffe0, 64'h20, 32'h20);
		fin(1'b0, 3'h0);
		u_mem.store[64'h9010] = dsc(4'h0, 32'h10, 64'ha000);
		for (int i = 0; i < 6; i++) begin
			u_mem.store[64'h9000] = dsc(ty[i], 32'h10, 64'h0);
			issue(1'b1, 64'h9000, {4'h2, 28'h0, 32'h20}, 32'h10);
			fin(1'b1, cd[i]);
		end
		u_mem.store[64'h9000] = dsc(4'h0, 32'h10, 64'ha000);
		u_mem.store[64'h9010] = dsc(4'h3, 32'h10, 64'hb000);
		xp(64'ha000, 32'h10);
		issue(1'b1, 64'h9000, {4'h3, 28'h0, 32'h20}, 32'h20);
		fin(1'b1, 3'h2);
		issue(1'b1, 64'hfffffffffffffff0, 64'h20, 32'h20);
		fin(1'b1, 3'h4);
		issue(1'b1, 64'h100, {8'h01, 24'h0, 32'h10}, 32'h10);
		fin(1'b1, 3'h6);
		// Last segment of one descriptor cannot cover the length
		xp(64'ha000, 32'h10);
		issue(1'b1, 64'h9000, {4'h3, 28'h0, 32'h10}, 32'h20);
		fin(1'b1, 3'h5);
	endtask
	task automatic end_sim;
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk({cr, busy, xv, mrv, done, err}, 6'h20);
		t_page();
		t_chain();
		t_sgl();
		end_sim();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end
endmodule

// File: dplw_walker.sv
// Data pointer list walker: page pointer lists and scatter-gather segments
`timescale 1ns/1ps
`include "dplw_defs.svh"

// Behaviour
// - Entry is 64 bits, bits 1:0 reserved
// - Offset spans log2(page)-1 down to 2
// - Last list slot chains to next page
// - List continues after command's own entries
// - First entry may start mid-page
// - List pointer qword aligned, any offset
// - Entry count derived from length, page size
// - Fixed entries allow any fetch order
// - Page size from configuration field
// - Data buffers: any byte address, length
// - Descriptors 16 bytes, packed back-to-back
// - Abort on misplaced or extra chaining descriptor
// - Abort on chaining inside last segment
// - Reserved or unsupported type is error
// - All-zero descriptor transfers nothing
// - Type in byte 15 bits 7:4
// - Address plus length past 2^64 errors
module dplw_walker #(
	parameter int FIFO_DEPTH = 8,
	parameter logic [3:0] MAX_MPS = `DPLW_MPS_MAX
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Command: pointer kind, two pointer slots, byte length
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic CMD_SGL,
	input wire logic [63:0] CMD_PTR1,
	input wire logic [63:0] CMD_PTR2,
	input wire logic [31:0] CMD_LEN,
	// Memory page size configuration, page = 4KB << value
	input wire logic [3:0] MEMORY_PAGE_SIZE_CONFIG,
	// Read request for pointer structures in host memory
	output logic MEM_REQ_VALID,
	input wire logic MEM_REQ_READY,
	output logic [63:0] MEM_REQ_ADDR,
	input wire logic MEM_RSP_VALID,
	input wire logic [127:0] MEM_RSP_DATA,
	// Transfer stream: host address and byte count
	output logic XFER_VALID,
	input wire logic XFER_READY,
	output logic [63:0] XFER_ADDR,
	output logic [31:0] XFER_LEN,
	// Completion
	output logic BUSY,
	output logic DONE,
	output logic ERR,
	output logic [2:0] ERR_CODE
);
	// Page shift must keep a whole page length inside 32 bits
	if (MAX_MPS > 4'h0f || FIFO_DEPTH < 2) begin : g_chk
		$error("dplw_walker: unsupported MAX_MPS or FIFO_DEPTH");
	end

	// Queue pointers wrap by themselves, so depth is a power of two
	if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk_pow2
		$error("dplw_walker: FIFO_DEPTH must be a power of two");
	end

	dplw_pkg::dplw_walk_t q, d;

	logic fifo_ready;
	logic [95:0] fifo_out;
	logic [63:0] page_bytes;
	logic [63:0] off_mask;
	logic [63:0] first_off;
	logic [63:0] first_room;
	logic [63:0] entry;
	logic last_slot;
	logic [3:0] dtype;
	logic [3:0] dzero;
	logic [63:0] daddr;
	logic [31:0] dlen;
	logic [64:0] dend;
	logic dwrap;
	logic [31:0] rem_after;

	// ************************************************************
	// Page geometry
	// ************************************************************

	// Page size taken from the latched configuration
	assign page_bytes = 64'h1 << (`DPLW_PAGE_SHIFT_BASE + {2'h0, q.mps});
	assign off_mask = page_bytes - 64'h1;
	// Offset of first entry, reserved low bits dropped
	assign first_off = q.ptr1 & off_mask & ~`DPLW_ENTRY_RSVD_MASK;
	assign first_room = page_bytes - first_off;

	// Fetched list entry with reserved bits cleared
	assign entry = MEM_RSP_DATA[63:0] & ~`DPLW_ENTRY_RSVD_MASK;
	// The slot just before the page end holds the chain pointer
	assign last_slot = ((q.list_addr + `DPLW_ENTRY_BYTES) & off_mask)
		== 64'h0;

	// ************************************************************
	// Descriptor fields
	// ************************************************************

	assign dtype = q.desc[`DPLW_DESC_TYPE_LSB +: 4];
	assign dzero = q.desc[`DPLW_DESC_ZERO_LSB +: 4];
	assign daddr = q.desc[`DPLW_DESC_ADDR_LSB +: 64];
	assign dlen = q.desc[`DPLW_DESC_LEN_LSB +: 32];
	// End address past 2^64 is an error; exactly 2^64 is allowed
	assign dend = {1'b0, daddr} + {33'h0, dlen};
	assign dwrap = dend[64] && (dend[63:0] != 64'h0);

	// Bytes still owed once the pending entry is queued
	assign rem_after = q.rem - q.em_len;

	// ************************************************************
	// Handshake and status outputs
	// ************************************************************

	// Ready, request and busy decode the state register directly; DONE and ERR come from their own flops
	assign CMD_READY = (q.st == dplw_pkg::ST_IDLE);
	assign MEM_REQ_VALID = (q.st == dplw_pkg::ST_PG_FETCH) ||
		(q.st == dplw_pkg::ST_SG_FETCH);
	assign MEM_REQ_ADDR = q.list_addr;
	assign BUSY = (q.st != dplw_pkg::ST_IDLE);
	assign DONE = q.done;
	assign ERR = q.err;
	assign ERR_CODE = q.err_code;
	assign XFER_ADDR = fifo_out[95:32];
	assign XFER_LEN = fifo_out[31:0];

	// ************************************************************
	// Walker
	// ************************************************************

	// Next state; only one structure fetch is outstanding at a time
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.err = 1'b0;
		case (q.st)
			dplw_pkg::ST_IDLE: begin
				if (CMD_VALID) begin
					d.scatter_gather_list = CMD_SGL;
					d.ptr1 = CMD_PTR1;
					d.ptr2 = CMD_PTR2;
					d.rem = CMD_LEN;
					d.mps = (MEMORY_PAGE_SIZE_CONFIG > MAX_MPS) ?
						MAX_MPS : MEMORY_PAGE_SIZE_CONFIG;
					d.err_code = dplw_pkg::ER_NONE;
					// The command's own descriptor is a segment of one
					d.desc = {CMD_PTR2, CMD_PTR1};
					d.seg_left = 28'h1;
					d.in_last = 1'b0;
					if (CMD_LEN == 32'h0) begin
						d.st = dplw_pkg::ST_FINISH;
					end else if (CMD_SGL) begin
						d.st = dplw_pkg::ST_SG_EVAL;
					end else begin
						d.st = dplw_pkg::ST_PG_FIRST;
					end
				end
			end
			dplw_pkg::ST_PG_FIRST: begin
				// First entry may begin at any dword in its page
				d.em_addr = q.ptr1 & ~`DPLW_ENTRY_RSVD_MASK;
				d.em_len = ({32'h0, q.rem} < first_room) ?
					q.rem : first_room[31:0];
				d.ret = dplw_pkg::ST_PG_SECOND;
				d.st = dplw_pkg::ST_EMIT;
			end
			dplw_pkg::ST_PG_SECOND: begin
				// Second slot is data if one page remains, else a list
				if ({32'h0, q.rem} <= page_bytes) begin
					d.em_addr = q.ptr2 & ~`DPLW_ENTRY_RSVD_MASK;
					d.em_len = q.rem;
					d.ret = dplw_pkg::ST_FINISH;
					d.st = dplw_pkg::ST_EMIT;
				end else begin
					// List may begin mid-page; walk continues there
					d.list_addr = q.ptr2 & ~`DPLW_LIST_ALIGN_MASK;
					d.st = dplw_pkg::ST_PG_FETCH;
				end
			end
			dplw_pkg::ST_PG_FETCH: begin
				// Request and address hold until memory takes them
				if (MEM_REQ_READY) begin
					d.st = dplw_pkg::ST_PG_WAIT;
				end
			end
			dplw_pkg::ST_PG_WAIT: begin
				if (MEM_RSP_VALID) begin
					if (last_slot && ({32'h0, q.rem} > page_bytes)) begin
						// Chain to next list page, fetched only now
						d.list_addr = entry;
						d.st = dplw_pkg::ST_PG_FETCH;
					end else begin
						// Later entries start on a page boundary
						d.em_addr = entry;
						d.em_len = ({32'h0, q.rem} < page_bytes) ?
							q.rem : page_bytes[31:0];
						// Fixed-size entries allow any order; kept in order
						d.list_addr = q.list_addr + `DPLW_ENTRY_BYTES;
						d.ret = dplw_pkg::ST_PG_FETCH;
						d.st = dplw_pkg::ST_EMIT;
					end
				end
			end
			dplw_pkg::ST_SG_FETCH: begin
				// Request and address hold until memory takes them
				if (MEM_REQ_READY) begin
					d.st = dplw_pkg::ST_SG_WAIT;
				end
			end
			dplw_pkg::ST_SG_WAIT: begin
				// Whole descriptor lands at once; step to next slot
				if (MEM_RSP_VALID) begin
					d.desc = MEM_RSP_DATA;
					d.list_addr = q.list_addr + `DPLW_DESC_BYTES;
					d.st = dplw_pkg::ST_SG_EVAL;
				end
			end
			dplw_pkg::ST_SG_EVAL: begin
				case (dtype)
					dplw_pkg::DT_DATA: begin
						d.seg_left = q.seg_left - 28'h1;
						if (dzero != 4'h0) begin
							d.err_code = dplw_pkg::ER_ZERO;
							d.st = dplw_pkg::ST_FINISH;
						end else if (dwrap) begin
							d.err_code = dplw_pkg::ER_WRAP;
							d.st = dplw_pkg::ST_FINISH;
						end else if (dlen == 32'h0) begin
							// Null descriptor moves no data
							d.st = dplw_pkg::ST_SG_NEXT;
						end else begin
							// Any byte address and length pass through
							d.em_addr = daddr;
							d.em_len = (dlen < q.rem) ? dlen : q.rem;
							d.ret = dplw_pkg::ST_SG_NEXT;
							d.st = dplw_pkg::ST_EMIT;
						end
					end
					dplw_pkg::DT_SEG, dplw_pkg::DT_LAST: begin
						if (q.seg_left != 28'h1) begin
							// Chaining before the last slot
							d.err_code = dplw_pkg::ER_CHAIN_POS;
							d.st = dplw_pkg::ST_FINISH;
						end else if (q.in_last) begin
							d.err_code = dplw_pkg::ER_LAST_CHAIN;
							d.st = dplw_pkg::ST_FINISH;
						end else begin
							d.list_addr = daddr;
							d.seg_left = dlen[31:`DPLW_DESC_SHIFT];
							d.in_last = (dtype == dplw_pkg::DT_LAST);
							d.st = dplw_pkg::ST_SG_NEXT;
						end
					end
					default: begin
						// Bit bucket, reserved and vendor codes unsupported
						d.err_code = dplw_pkg::ER_TYPE;
						d.st = dplw_pkg::ST_FINISH;
					end
				endcase
			end
			dplw_pkg::ST_SG_NEXT: begin
				// Descriptors ran out before the length was met
				if (q.seg_left == 28'h0) begin
					d.err_code = dplw_pkg::ER_SHORT;
					d.st = dplw_pkg::ST_FINISH;
				end else begin
					d.st = dplw_pkg::ST_SG_FETCH;
				end
			end
			dplw_pkg::ST_EMIT: begin
				// Stalls here while the queue is full
				if (fifo_ready) begin
					d.rem = rem_after;
					d.st = (rem_after == 32'h0) ?
						dplw_pkg::ST_FINISH : q.ret;
				end
			end
			dplw_pkg::ST_FINISH: begin
				// One-cycle pulse; the cause code stays until next take
				d.done = (q.err_code == dplw_pkg::ER_NONE);
				d.err = (q.err_code != dplw_pkg::ER_NONE);
				d.st = dplw_pkg::ST_IDLE;
			end
			default: begin
				// Unused codes fall back to idle
				d.st = dplw_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK) begin
		if (RST) begin
			q.st <= dplw_pkg::ST_IDLE;
			q.ret <= dplw_pkg::ST_IDLE;
			q.scatter_gather_list <= 1'b0;
			q.mps <= 4'h0;
			q.rem <= `DPLW_RST_LEN;
			q.ptr1 <= `DPLW_RST_ADDR;
			q.ptr2 <= `DPLW_RST_ADDR;
			q.list_addr <= `DPLW_RST_ADDR;
			q.em_addr <= `DPLW_RST_ADDR;
			q.em_len <= `DPLW_RST_LEN;
			q.seg_left <= `DPLW_RST_SEGLEFT;
			q.in_last <= 1'b0;
			q.desc <= 128'h0;
			q.done <= 1'b0;
			q.err <= 1'b0;
			q.err_code <= dplw_pkg::ER_NONE;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Transfer queue
	// ************************************************************

	// Decouples the walk from a slow data mover
	dplw_fifo #(
		.W(96),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst(RST),
		.in_valid(q.st == dplw_pkg::ST_EMIT),
		.in_ready(fifo_ready),
		.in_data({q.em_addr, q.em_len}),
		.out_valid(XFER_VALID),
		.out_ready(XFER_READY),
		.out_data(fifo_out)
	);
endmodule
